// ==== src/sspm_top.sv ====
// ======================================
// What this block does
// - enable before access picks config or flags
// - write with enable applies config then enables
// - frame length is width field plus one
// - bit 4 selects msb or lsb first
// - phase bit swaps shift and latch edges
// - polarity bit sets idle clock level
// - four enables gate error flagging
// - auto reset on rate error when enabled
// - master drives clock, slave uses pin clock
// - low status field counts shifted bits
// - transmit error: slave starts without new data
// - receive error: overrun of unread buffer
// - phase error: data changes at sample edge
// - rate error: slave clock off by two
// - transfer start sets busy, tx request
// - buffer loads shift register when empty
// - frame end fills rx buffer, clears busy unless tx buffer full
// - send and receive share one shift register
// - buffers right aligned, lsb at bit 0
// - dedicated 16-bit baud generator
// - master first bit at next baud tick
// - slave first bit driven at load
// - disabled port holds clock and data high
`timescale 1ns/1ps
`default_nettype none
module sspm_top
   import sspm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [15:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [15:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic SCLK_I,
   output logic SCLK_O,
   output logic SCLK_OE_N,
   input wire logic MASTER_OUT_SLAVE_IN_PIN_I,
   output logic MASTER_OUT_SLAVE_IN_PIN_O,
   output logic MASTER_OUT_SLAVE_IN_PIN_OE_N,
   input wire logic MASTER_IN_SLAVE_OUT_PIN_I,
   output logic MASTER_IN_SLAVE_OUT_PIN_O,
   output logic MASTER_IN_SLAVE_OUT_PIN_OE_N,
   output logic TX_IRQ_REQ,
   output logic RX_IRQ_REQ
);

   typedef struct packed {
      logic aw_got;
      logic [15:0] awaddr;
      logic w_got;
      logic [15:0] wdata;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic en;
      sspm_cfg_type cfg;
      sspm_flag_type flg;
      logic [15:0] tx_buffer;
      logic tx_full;
      logic tx_fresh;
      logic [15:0] rx_buffer;
      logic rx_unread;
      logic [15:0] shreg;
      logic [3:0] shift_bit_counter;
      sspm_state_type st;
      logic [15:0] reload;
      logic [15:0] baud_cnt;
      logic sclk;
      logic dout;
      logic half;
      logic [1:0] sclk_sync;
      logic sclk_prev;
      logic [1:0] din_sync;
      logic din_prev;
      logic [17:0] gap_cnt;
      logic tx_irq;
      logic rx_irq;
   } sspm_state_all_type;

   sspm_state_all_type s_ff;
   sspm_state_all_type nxt_s;

   // pick next bit from the serial side of the shift register
   function automatic logic out_bit(input logic [15:0] v, input logic hb, input logic [3:0] w);
      out_bit = hb ? v[w] : v[0];
   endfunction

   // shift in one bit; frame stays right aligned in bits w..0
   function automatic logic [15:0] shift_in(input logic [15:0] v, input logic hb,
                                            input logic [3:0] w, input logic b);
      logic [15:0] r;
      r = v;
      if (hb) begin
         r = {v[14:0], b};
      end else begin
         r = v >> 1;
         r[w] = b;
      end
      shift_in = r;
   endfunction

   logic din;
   logic lead_edge;
   logic trail_edge;
   logic sh_edge;
   logic lt_edge;
   logic wr_fire;
   logic rd_fire;
   logic [15:0] ctrl_rd;
   logic [17:0] expect_half;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.tx_irq = 1'b0;
      nxt_s.rx_irq = 1'b0;
      din = s_ff.cfg.master ? MASTER_IN_SLAVE_OUT_PIN_I : MASTER_OUT_SLAVE_IN_PIN_I;
      lead_edge = 1'b0;
      trail_edge = 1'b0;
      expect_half = {2'h0, s_ff.reload} + 18'h00001;
      ctrl_rd = {s_ff.en, s_ff.cfg.master, 1'b0, s_ff.flg.bsy, s_ff.flg.be, s_ff.flg.pe,
                 s_ff.flg.re, s_ff.flg.te, 4'h0, s_ff.shift_bit_counter};
      if (!s_ff.en) begin
         ctrl_rd = {1'b0, s_ff.cfg.master, 1'b0, s_ff.cfg.aren, s_ff.cfg.ben, s_ff.cfg.pen,
                    s_ff.cfg.ren, s_ff.cfg.ten, 1'b0, s_ff.cfg.po, s_ff.cfg.ph,
                    s_ff.cfg.hb, s_ff.cfg.width};
      end
      // ======================================
      // axi write
      if (AWVALID && !s_ff.aw_got) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.awaddr = AWADDR;
      end
      if (WVALID && !s_ff.w_got) begin
         nxt_s.w_got = 1'b1;
         nxt_s.wdata = WDATA[15:0];
      end
      wr_fire = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
      if (s_ff.bvalid && BREADY) begin
         nxt_s.bvalid = 1'b0;
      end
      // ======================================
      // axi read
      rd_fire = ARVALID && !s_ff.rvalid;
      if (s_ff.rvalid && RREADY) begin
         nxt_s.rvalid = 1'b0;
      end
      if (rd_fire) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = SSPM_RESP_OKAY;
         nxt_s.rdata = 32'h0000_0000;
         unique case (ARADDR)
            SSPM_CTRL_OFFS: nxt_s.rdata[15:0] = ctrl_rd;
            SSPM_TXB_OFFS: nxt_s.rdata[15:0] = s_ff.tx_buffer;
            SSPM_RXB_OFFS: begin
               nxt_s.rdata[15:0] = s_ff.rx_buffer;
               nxt_s.rx_unread = 1'b0;
            end
            SSPM_BAUD_OFFS: nxt_s.rdata[15:0] = s_ff.baud_cnt;
            SSPM_EVT_OFFS: nxt_s.rdata[1:0] = {s_ff.rx_unread, s_ff.tx_full};
            default: nxt_s.rresp = SSPM_RESP_SLVERR;
         endcase
      end
      // ======================================
      // baud generator, runs only while enabled master
      if (s_ff.en && s_ff.cfg.master) begin
         if (s_ff.baud_cnt == 16'h0000) begin
            nxt_s.baud_cnt = s_ff.reload;
         end else begin
            nxt_s.baud_cnt = s_ff.baud_cnt - 16'h0001;
         end
      end else begin
         nxt_s.baud_cnt = s_ff.reload;
      end
      // ======================================
      // slave clock and data sampling
      nxt_s.sclk_sync = {s_ff.sclk_sync[0], SCLK_I};
      nxt_s.sclk_prev = s_ff.sclk_sync[1];
      nxt_s.din_sync = {s_ff.din_sync[0], din};
      nxt_s.din_prev = s_ff.din_sync[1];
      if (s_ff.en && !s_ff.cfg.master) begin
         lead_edge = (s_ff.sclk_sync[1] != s_ff.sclk_prev) && (s_ff.sclk_prev == s_ff.cfg.po);
         trail_edge = (s_ff.sclk_sync[1] != s_ff.sclk_prev) && (s_ff.sclk_prev != s_ff.cfg.po);
      end
      // ======================================
      // shift engine
      sh_edge = s_ff.cfg.ph ? trail_edge : lead_edge;
      lt_edge = s_ff.cfg.ph ? lead_edge : trail_edge;
      if (s_ff.en) begin
         if (!s_ff.cfg.master && s_ff.st == SSPM_SHIFT) begin
            if (s_ff.sclk_sync[1] != s_ff.sclk_prev) begin
               nxt_s.gap_cnt = 18'h00000;
               // too fast: faster than half the expected half period
               if (s_ff.cfg.ben && (s_ff.gap_cnt < (expect_half >> 1))) begin
                  nxt_s.flg.be = 1'b1;
               end
            end else begin
               nxt_s.gap_cnt = s_ff.gap_cnt + 18'h00001;
               if (s_ff.cfg.ben && (s_ff.gap_cnt > (expect_half << 1))) begin
                  nxt_s.flg.be = 1'b1;
               end
            end
         end
         unique case (s_ff.st)
            SSPM_IDLE: begin
               nxt_s.sclk = s_ff.cfg.po;
               if (s_ff.tx_full) begin
                  nxt_s.shreg = s_ff.tx_buffer;
                  nxt_s.tx_full = 1'b0;
                  nxt_s.shift_bit_counter = 4'h0;
                  nxt_s.st = SSPM_LOADED;
                  if (!s_ff.cfg.master) begin
                     nxt_s.dout = out_bit(s_ff.tx_buffer, s_ff.cfg.hb, s_ff.cfg.width);
                  end
               end else if (!s_ff.cfg.master && (lead_edge || trail_edge)) begin
                  // slave clocked with no new data: old contents go out
                  nxt_s.shift_bit_counter = 4'h0;
                  nxt_s.st = SSPM_SHIFT;
                  nxt_s.flg.bsy = 1'b1;
                  nxt_s.tx_irq = 1'b1;
                  nxt_s.gap_cnt = 18'h00000;
                  if (s_ff.cfg.ten) begin
                     nxt_s.flg.te = 1'b1;
                  end
               end
            end
            SSPM_LOADED: begin
               if (s_ff.cfg.master ? (s_ff.baud_cnt == 16'h0000) : (lead_edge || trail_edge)) begin
                  nxt_s.st = SSPM_SHIFT;
                  nxt_s.flg.bsy = 1'b1;
                  nxt_s.tx_irq = 1'b1;
                  nxt_s.gap_cnt = 18'h00000;
                  nxt_s.half = 1'b0;
                  if (!s_ff.cfg.master && s_ff.cfg.ten && !s_ff.tx_fresh) begin
                     nxt_s.flg.te = 1'b1;
                  end
                  nxt_s.tx_fresh = 1'b0;
                  if (s_ff.cfg.master) begin
                     nxt_s.dout = out_bit(s_ff.shreg, s_ff.cfg.hb, s_ff.cfg.width);
                  end else begin
                     sh_edge = 1'b0;
                  end
               end
            end
            SSPM_SHIFT: begin
               if (s_ff.cfg.master && s_ff.baud_cnt == 16'h0000) begin
                  // master clock toggles every baud underflow
                  nxt_s.sclk = !s_ff.sclk;
                  // leading edge latches only with phase set
                  lt_edge = (s_ff.sclk == s_ff.cfg.po) == s_ff.cfg.ph;
                  sh_edge = !lt_edge;
               end
               if (lt_edge) begin
                  if (s_ff.cfg.pen && (s_ff.din_sync[1] != s_ff.din_prev)) begin
                     nxt_s.flg.pe = 1'b1;
                  end
                  nxt_s.shreg = shift_in(s_ff.shreg, s_ff.cfg.hb, s_ff.cfg.width,
                                         s_ff.din_sync[1]);
                  nxt_s.shift_bit_counter = s_ff.shift_bit_counter + 4'h1;
                  if (s_ff.shift_bit_counter == s_ff.cfg.width) begin
                     nxt_s.rx_buffer = shift_in(s_ff.shreg, s_ff.cfg.hb, s_ff.cfg.width,
                                                s_ff.din_sync[1]);
                     nxt_s.rx_irq = 1'b1;
                     nxt_s.rx_unread = 1'b1;
                     // last edge still toggles; idle state parks the clock next cycle
                     nxt_s.st = SSPM_IDLE;
                     if (s_ff.rx_unread && s_ff.cfg.ren) begin
                        nxt_s.flg.re = 1'b1;
                     end
                     if (!s_ff.tx_full) begin
                        nxt_s.flg.bsy = 1'b0;
                     end
                  end
               end else if (sh_edge) begin
                  nxt_s.dout = out_bit(s_ff.shreg, s_ff.cfg.hb, s_ff.cfg.width);
               end
            end
         endcase
         if (nxt_s.flg.be && !s_ff.flg.be && s_ff.cfg.aren) begin
            nxt_s.st = SSPM_IDLE;
            nxt_s.shift_bit_counter = 4'h0;
            nxt_s.flg.bsy = 1'b0;
            nxt_s.sclk = s_ff.cfg.po;
         end
      end else begin
         nxt_s.st = SSPM_IDLE;
         nxt_s.sclk = 1'b1;
         nxt_s.dout = 1'b1;
      end
      // ======================================
      // register writes; flags set above are kept, and a write never clears a flag
      if (wr_fire) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = SSPM_RESP_OKAY;
         unique case (s_ff.awaddr)
            SSPM_CTRL_OFFS: begin
               nxt_s.en = s_ff.wdata[SSPM_EN_BIT];
               nxt_s.cfg.master = s_ff.wdata[SSPM_MS_BIT];
               if (!s_ff.wdata[SSPM_EN_BIT]) begin
                  // release lines on the same edge that drops the enable
                  nxt_s.st = SSPM_IDLE;
                  nxt_s.sclk = 1'b1;
                  nxt_s.dout = 1'b1;
               end
               if (!s_ff.en) begin
                  nxt_s.cfg.aren = s_ff.wdata[SSPM_AREN_BIT];
                  nxt_s.cfg.ben = s_ff.wdata[SSPM_BEN_BIT];
                  nxt_s.cfg.pen = s_ff.wdata[SSPM_PEN_BIT];
                  nxt_s.cfg.ren = s_ff.wdata[SSPM_REN_BIT];
                  nxt_s.cfg.ten = s_ff.wdata[SSPM_TEN_BIT];
                  nxt_s.cfg.po = s_ff.wdata[SSPM_PO_BIT];
                  nxt_s.cfg.ph = s_ff.wdata[SSPM_PH_BIT];
                  nxt_s.cfg.hb = s_ff.wdata[SSPM_HB_BIT];
                  nxt_s.cfg.width = s_ff.wdata[3:0];
               end else begin
                  nxt_s.flg.be = nxt_s.flg.be | (s_ff.flg.be & s_ff.wdata[SSPM_BE_BIT]);
                  nxt_s.flg.pe = nxt_s.flg.pe | (s_ff.flg.pe & s_ff.wdata[SSPM_PE_BIT]);
                  nxt_s.flg.re = nxt_s.flg.re | (s_ff.flg.re & s_ff.wdata[SSPM_RE_BIT]);
                  nxt_s.flg.te = nxt_s.flg.te | (s_ff.flg.te & s_ff.wdata[SSPM_TE_BIT]);
                  if (!nxt_s.flg.be || s_ff.wdata[SSPM_BE_BIT]) begin
                     nxt_s.flg.be = nxt_s.flg.be & (s_ff.wdata[SSPM_BE_BIT] | (nxt_s.flg.be
                                    != s_ff.flg.be));
                  end
               end
            end
            SSPM_TXB_OFFS: begin
               nxt_s.tx_buffer = s_ff.wdata;
               nxt_s.tx_full = 1'b1;
               nxt_s.tx_fresh = 1'b1;
            end
            SSPM_BAUD_OFFS: nxt_s.reload = s_ff.wdata;
            SSPM_RXB_OFFS, SSPM_EVT_OFFS: nxt_s.bresp = SSPM_RESP_OKAY;
            default: nxt_s.bresp = SSPM_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s_ff <= '0;
         s_ff.sclk <= 1'b1;
         s_ff.dout <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ======================================
   // outputs straight from state flops
   assign AWREADY = !s_ff.aw_got;
   assign WREADY = !s_ff.w_got;
   assign BVALID = s_ff.bvalid;
   assign BRESP = s_ff.bresp;
   assign ARREADY = !s_ff.rvalid;
   assign RVALID = s_ff.rvalid;
   assign RDATA = s_ff.rdata;
   assign RRESP = s_ff.rresp;
   assign SCLK_O = s_ff.sclk;
   assign SCLK_OE_N = !(s_ff.en && s_ff.cfg.master);
   assign MASTER_OUT_SLAVE_IN_PIN_O = s_ff.dout;
   assign MASTER_OUT_SLAVE_IN_PIN_OE_N = !(s_ff.en && s_ff.cfg.master);
   assign MASTER_IN_SLAVE_OUT_PIN_O = s_ff.dout;
   assign MASTER_IN_SLAVE_OUT_PIN_OE_N = !(s_ff.en && !s_ff.cfg.master);
   assign TX_IRQ_REQ = s_ff.tx_irq;
   assign RX_IRQ_REQ = s_ff.rx_irq;
endmodule
`default_nettype wire

// ==== src/sspm_pkg.sv ====
package sspm_pkg;
   // ======================================
   // register map
   localparam logic [15:0] SSPM_CTRL_OFFS = 16'hFFB2;
   localparam logic [15:0] SSPM_TXB_OFFS = 16'hFFB4;
   localparam logic [15:0] SSPM_RXB_OFFS = 16'hFFB8;
   localparam logic [15:0] SSPM_BAUD_OFFS = 16'hFFBC;
   localparam logic [15:0] SSPM_EVT_OFFS = 16'hFFC0;
   localparam logic [15:0] SSPM_CTRL_RST = 16'h0000;
   localparam logic [15:0] SSPM_BAUD_RST = 16'h0000;
   // ======================================
   // control field positions
   localparam int SSPM_EN_BIT = 15;
   localparam int SSPM_MS_BIT = 14;
   localparam int SSPM_AREN_BIT = 12;
   localparam int SSPM_BEN_BIT = 11;
   localparam int SSPM_PEN_BIT = 10;
   localparam int SSPM_REN_BIT = 9;
   localparam int SSPM_TEN_BIT = 8;
   localparam int SSPM_PO_BIT = 6;
   localparam int SSPM_PH_BIT = 5;
   localparam int SSPM_HB_BIT = 4;
   localparam int SSPM_BSY_BIT = 12;
   localparam int SSPM_BE_BIT = 11;
   localparam int SSPM_PE_BIT = 10;
   localparam int SSPM_RE_BIT = 9;
   localparam int SSPM_TE_BIT = 8;
   // only these bits are stored as configuration
   localparam logic [15:0] SSPM_CFG_MASK = 16'h5F7F;
   // ======================================
   // rate watchdog: slave half periods vs expected
   localparam logic [17:0] SSPM_RATE_MIN_DIV = 18'h00002;
   localparam logic [1:0] SSPM_RESP_OKAY = 2'h0;
   localparam logic [1:0] SSPM_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SSPM_IDLE = 2'b00,
      SSPM_LOADED = 2'b01,
      SSPM_SHIFT = 2'b11
   } sspm_state_type;

   typedef struct packed {
      logic master;
      logic aren;
      logic ben;
      logic pen;
      logic ren;
      logic ten;
      logic po;
      logic ph;
      logic hb;
      logic [3:0] width;
   } sspm_cfg_type;

   typedef struct packed {
      logic bsy;
      logic be;
      logic pe;
      logic re;
      logic te;
   } sspm_flag_type;
endpackage

// ==== tb/sspm_spi_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspm_spi_slave (
   input wire logic clk,
   input wire logic sel,
   input wire logic po,
   input wire logic ph,
   input wire logic hb,
   input wire logic [3:0] wid,
   input wire logic [15:0] pat,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic [15:0] got
);
   // ==========
   // far side slave: never drives the clock line
   logic prev;
   int idx;
   int pos;
   assign pos = hb ? int'(wid) - idx : idx;
   always_ff @(posedge clk) begin
      prev <= sclk;
      if (!sel) begin
         idx <= 0;
         got <= 16'h0000;
      end else if (sclk != prev && sclk == (po ^ ph)) begin
         got[pos] <= mosi;
         idx <= idx + 1;
      end
   end
   // deselected or past the frame: the pull-up holds the line high
   assign miso = (!sel || idx > int'(wid)) ? 1'b1 : pat[pos];
endmodule
`default_nettype wire

// ==== tb/sspm_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspm_top_chk
   import sspm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic [15:0] ARADDR,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic [1:0] RRESP,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic SCLK_O,
   input wire logic SCLK_OE_N,
   input wire logic MASTER_OUT_SLAVE_IN_PIN_O,
   input wire logic MASTER_OUT_SLAVE_IN_PIN_OE_N,
   input wire logic MASTER_IN_SLAVE_OUT_PIN_O,
   input wire logic MASTER_IN_SLAVE_OUT_PIN_OE_N,
   input wire logic TX_IRQ_REQ,
   input wire logic RX_IRQ_REQ
);
   logic ar_map;
   logic off;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   assign ar_map = ARADDR inside {SSPM_CTRL_OFFS, SSPM_TXB_OFFS, SSPM_RXB_OFFS,
      SSPM_BAUD_OFFS, SSPM_EVT_OFFS};
   // both pins released only while the port is disabled
   assign off = SCLK_OE_N && MASTER_IN_SLAVE_OUT_PIN_OE_N;
   // ==========
   // register bus
   a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
      else $error("write answer not on time");
   a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write answer dropped");
   a_read_resp: assert property (ARVALID && ARREADY |=> RVALID &&
      RRESP == ($past(ar_map) ? SSPM_RESP_OKAY : SSPM_RESP_SLVERR))
      else $error("read answer wrong");
   a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read answer dropped");
   // ==========
   // pins and requests
   a_master_pins: assert property (SCLK_OE_N == MASTER_OUT_SLAVE_IN_PIN_OE_N)
      else $error("master pins disagree");
   a_one_driver: assert property (!MASTER_IN_SLAVE_OUT_PIN_OE_N |-> SCLK_OE_N)
      else $error("slave drives clock");
   a_idle_high: assert property (off |-> SCLK_O && MASTER_OUT_SLAVE_IN_PIN_O && MASTER_IN_SLAVE_OUT_PIN_O)
      else $error("disabled outputs not high");
   a_tx_pulse: assert property (TX_IRQ_REQ |=> !TX_IRQ_REQ)
      else $error("transmit request too long");
   a_rx_pulse: assert property (RX_IRQ_REQ |=> !RX_IRQ_REQ)
      else $error("receive request too long");
   a_req_enabled: assert property (TX_IRQ_REQ || RX_IRQ_REQ |-> !off)
      else $error("request while disabled");
endmodule
bind sspm_top sspm_top_chk u_chk (.CLK, .RST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP,
   .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
   .SCLK_O, .SCLK_OE_N, .MASTER_OUT_SLAVE_IN_PIN_O, .MASTER_OUT_SLAVE_IN_PIN_OE_N, .MASTER_IN_SLAVE_OUT_PIN_O, .MASTER_IN_SLAVE_OUT_PIN_OE_N, .TX_IRQ_REQ,
   .RX_IRQ_REQ);
`default_nettype wire

// ==== tb/sspm_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sspm_top_tb
   import sspm_pkg::*;
;
   logic CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID;
   logic ARREADY, RVALID, SCLK_I, SCLK_O, SCLK_OE_N, MASTER_OUT_SLAVE_IN_PIN_I, MASTER_OUT_SLAVE_IN_PIN_O, MASTER_OUT_SLAVE_IN_PIN_OE_N;
   logic MASTER_IN_SLAVE_OUT_PIN_I, MASTER_IN_SLAVE_OUT_PIN_O, MASTER_IN_SLAVE_OUT_PIN_OE_N, TX_IRQ_REQ, RX_IRQ_REQ, tb_sclk, sel, po, ph, hb, miso;
   logic [15:0] AWADDR, ARADDR, got, rd, m, pat;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB, wid;
   logic [1:0] BRESP, RRESP, rsp;
   logic [6:0] c;
   logic [6:0] cfgs [4] = '{7'h07, 7'h3F, 7'h51, 7'h6B};
   int fail_count = 0;
   int n_tests = 0;
   int n_tx = 0;
   int n_rx = 0;
   // ==========
   // wires: enabled driver wins, else far side or pull-up
   assign SCLK_I = SCLK_OE_N ? tb_sclk : SCLK_O;
   assign MASTER_OUT_SLAVE_IN_PIN_I = MASTER_OUT_SLAVE_IN_PIN_OE_N ? 1'b1 : MASTER_OUT_SLAVE_IN_PIN_O;
   assign MASTER_IN_SLAVE_OUT_PIN_I = MASTER_IN_SLAVE_OUT_PIN_OE_N ? miso : MASTER_IN_SLAVE_OUT_PIN_O;
   sspm_top dut (.CLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
      .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
      .RREADY, .SCLK_I, .SCLK_O, .SCLK_OE_N, .MASTER_OUT_SLAVE_IN_PIN_I, .MASTER_OUT_SLAVE_IN_PIN_O, .MASTER_OUT_SLAVE_IN_PIN_OE_N, .MASTER_IN_SLAVE_OUT_PIN_I,
      .MASTER_IN_SLAVE_OUT_PIN_O, .MASTER_IN_SLAVE_OUT_PIN_OE_N, .TX_IRQ_REQ, .RX_IRQ_REQ);
   sspm_spi_slave u_far (.clk(CLK), .sel, .po, .ph, .hb, .wid, .pat, .sclk(SCLK_I),
      .mosi(MASTER_OUT_SLAVE_IN_PIN_I), .miso, .got);
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // requests are one-cycle pulses, so count them at every edge
   always @(posedge CLK) begin
      if (TX_IRQ_REQ === 1'b1) n_tx++;
      if (RX_IRQ_REQ === 1'b1) n_rx++;
   end
   // ==========
   // tasks
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic tmo;
      fail_count++;
      $display("mismatch at %0t: wait ran out", $time);
      finish_test();
   endtask
   task automatic check(input logic [15:0] v, input logic [15:0] e);
      n_tests++;
      if (v !== e) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, v, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      int n;
      AWADDR <= a;
      WDATA <= {16'h0000, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge CLK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         if (BVALID) break;
      end
      rsp = BRESP;
      if (n == 40) tmo();
   endtask
   task automatic rd_reg(input logic [15:0] a);
      int n;
      ARADDR <= a;
      ARVALID <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge CLK);
         if (ARREADY) ARVALID <= 1'b0;
         if (RVALID) break;
      end
      rd = RDATA[15:0];
      rsp = RRESP;
      if (n == 40) tmo();
   endtask
   task automatic wait_rx(input int k);
      int n;
      for (n = 0; n < 2000 && n_rx < k; n++) @(posedge CLK);
      if (n_rx < k) tmo();
   endtask
   // ==========
   // main sequence
   initial begin
      RST = 1'b1;
      {AWADDR, ARADDR, WDATA} = '0;
      {AWVALID, WVALID, ARVALID, tb_sclk, sel} = '0;
      // answers always accepted, so back-to-back calls never toggle ready
      {BREADY, RREADY} = 2'b11;
      {po, ph, hb, wid} = '0;
      WSTRB = 4'hF;
      pat = 16'h56B3;
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      rd_reg(SSPM_CTRL_OFFS);
      check(rd, SSPM_CTRL_RST);
      rd_reg(16'hFFB0);
      check({14'h0000, rsp}, {14'h0000, SSPM_RESP_SLVERR});
      check({14'h0000, SCLK_O, MASTER_OUT_SLAVE_IN_PIN_O}, 16'h0003);
      wr(SSPM_BAUD_OFFS, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         wr(SSPM_CTRL_OFFS, 16'h0000);
         c = cfgs[i];
         {po, ph, hb, wid} <= c;
         m = 16'hFFFF >> (4'hF - c[3:0]);
         wr(SSPM_CTRL_OFFS, 16'hC200 | {9'h000, c});
         rd_reg(SSPM_CTRL_OFFS);
         check(rd & 16'hFFF0, 16'hC000);
         check({15'h0000, SCLK_O}, {15'h0000, c[6]});
         sel <= 1'b1;
         wr(SSPM_TXB_OFFS, 16'h9A6D);
         wait_rx(i + 1);
         check(got & m, 16'h9A6D & m);
         rd_reg(SSPM_RXB_OFFS);
         check(rd & m, pat & m);
         check(n_tx[15:0], 16'(i + 1));
         sel <= 1'b0;
      end
      // two frames with the receive buffer left unread
      for (int i = 5; i < 7; i++) begin
         @(posedge CLK);
         sel <= 1'b1;
         wr(SSPM_TXB_OFFS, 16'h0F0F);
         wait_rx(i);
         sel <= 1'b0;
      end
      rd_reg(SSPM_CTRL_OFFS);
      check(rd & 16'h1F00, 16'h0200);
      // slave without new transmit data, clock far slower than expected
      wr(SSPM_CTRL_OFFS, 16'h0000);
      wr(SSPM_CTRL_OFFS, 16'h8117);
      repeat (16) begin
         repeat (8) @(posedge CLK);
         tb_sclk <= ~tb_sclk;
      end
      rd_reg(SSPM_CTRL_OFFS);
      check(rd & 16'h0900, 16'h0100);
      wr(SSPM_TXB_OFFS, 16'h007F);
      repeat (6) @(posedge CLK);
      check({15'h0000, MASTER_IN_SLAVE_OUT_PIN_O}, 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire
